// *** lsd_defs.vh ***
`ifndef LSD_DEFS_VH
`define LSD_DEFS_VH

// Register byte offsets on the register bus.
`define LSD_ADR_CTRL0 4'h0
`define LSD_ADR_CTRL1 4'h4
`define LSD_ADR_STAT 4'h8

// Control register 0 fields.
`define LSD_C0_ON_LO 0
`define LSD_C0_REC_LO 9
`define LSD_C0_CMS_LO 18
`define LSD_C0_SVRD 20
`define LSD_C0_CLR 22
`define LSD_C0_EN 23
`define LSD_CTRL0_RST 24'h000000
`define LSD_CTRL1_RST 6'h00

// Status register fields.
`define LSD_S_FAULT 0
`define LSD_S_OC_LO 1
`define LSD_S_OL_LO 7
`define LSD_S_TW 13
`define LSD_S_TSD 14
`define LSD_S_OV 15
`define LSD_S_UV 16

// Timing, in the unit given, and the derived cycle counts.
`define LSD_CLK_KHZ 40000
`define LSD_FILT_TIME_US 32
`define LSD_FILT_CYC ((`LSD_FILT_TIME_US * `LSD_CLK_KHZ + 999) / 1000)
`define LSD_OL_TIME_US 1000
`define LSD_OL_CYC ((`LSD_OL_TIME_US * `LSD_CLK_KHZ + 999) / 1000)
`define LSD_REC_TIME_US 2000
`define LSD_REC_CYC ((`LSD_REC_TIME_US * `LSD_CLK_KHZ + 999) / 1000)
`define LSD_XC_TIME_NS 2000
`define LSD_XC_CYC ((`LSD_XC_TIME_NS * `LSD_CLK_KHZ + 999999) / 1000000)

`endif

// *** lsd_filter.v ***
`timescale 1ns/1ps
// Qualifies a condition that has held for CYC consecutive cycles.
module lsd_filter #(
  parameter CYC = 1280,
  parameter W = 17
) (
  input wire clk,
  input wire rst,
  input wire clr,
  input wire cond,
  output reg qual
);
  localparam integer LIM_I = CYC - 1;
  localparam [W-1:0] LIM = LIM_I[W-1:0];
  reg [W-1:0] cnt_reg;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= {W{1'b0}};
      qual <= 1'b0;
    end else if (clr || !cond) begin
      cnt_reg <= {W{1'b0}};
      qual <= 1'b0;
    end else if (cnt_reg != LIM) begin
      cnt_reg <= cnt_reg + 1'b1;
    end else begin
      qual <= 1'b1;
    end
  end
endmodule

// *** lsd_half_bridge.v ***
`timescale 1ns/1ps
// One half bridge: a switch may only turn on once the opposite one has
// been off for DT cycles; the outgoing switch then goes to fast turn-off.
module lsd_half_bridge #(
  parameter DT = 80,
  parameter W = 8
) (
  input wire clk,
  input wire rst,
  input wire want_hs,
  input wire want_ls,
  output reg hs_on,
  output reg ls_on,
  output reg hs_fast_off,
  output reg ls_fast_off
);
  localparam [W-1:0] LIM = DT[W-1:0];
  reg [W-1:0] hs_off_cnt_reg;
  reg [W-1:0] ls_off_cnt_reg;
  wire hs_done = (hs_off_cnt_reg == LIM);
  wire ls_done = (ls_off_cnt_reg == LIM);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      hs_off_cnt_reg <= LIM;
      ls_off_cnt_reg <= LIM;
      hs_on <= 1'b0;
      ls_on <= 1'b0;
      hs_fast_off <= 1'b0;
      ls_fast_off <= 1'b0;
    end else begin
      // The off counters lag the switch by one cycle, so a switch that was
      // on for a single cycle must still block the opposite one.
      hs_on <= want_hs && !want_ls && ls_done && !ls_on;
      ls_on <= want_ls && !want_hs && hs_done && !hs_on;
      hs_off_cnt_reg <= hs_on ? {W{1'b0}} : (hs_done ? LIM : hs_off_cnt_reg + 1'b1);
      ls_off_cnt_reg <= ls_on ? {W{1'b0}} : (ls_done ? LIM : ls_off_cnt_reg + 1'b1);
      hs_fast_off <= !hs_on && hs_done;
      ls_fast_off <= !ls_on && ls_done;
    end
  end
endmodule

// *** lsd_supervisor.v ***
`timescale 1ns/1ps
`include "lsd_defs.vh"
// Overview of operation
// - Power-on reset initialises all logic before any output drives.
// - Logic supply low forces all outputs off and clears all flags.
// - Writing enable bit 23 as zero enters standby, clearing all latched data.
// - Writing enable bit 23 as one selects active mode.
// - Each fault except open-load must persist 32 us before its flag sets.
// - Open-load and warning flags never change driver state.
// - Over-current disables its own driver; thermal shutdown disables all.
// - Without recovery bit, driver stays off until host clears its flag.
// - Supply over- or under-voltage flag forces all six outputs off.
// - With bit 20 clear, outputs return 32 us after supply recovers.
// - With bit 20 set, host must clear supply flags to restart.
// - Charge pump runs in active mode and stops in standby.
// - Warning and shutdown flags set after 32 us; shutdown turns all off.
// - Temperature flags latch; a clear works only below the trigger.
// - Clearing shutdown flag restores outputs to programmed state.
// - Open-load checked only on active outputs, after 1 ms.
// - Current sense is blanked 32 us after the selected driver turns on.
// - Bits 18 and 19 choose the monitored output.
// - Modulation enable makes output the AND of input and on bit.
// - Outputs 1-4 and 6 use input A; output 5 uses the shared pin.
// - Half bridge switches are separated by the cross-current delay.
// - With recovery bit set, driver restarts after the recovery time.
// - Writing bit 22 as one clears all status flags.
module lsd_supervisor #(
  parameter OL_CYC = `LSD_OL_CYC,
  parameter REC_CYC = `LSD_REC_CYC,
  parameter CNT_W = 17
) (
  input wire clk,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire vcc_ok,
  input wire [5:0] oc_raw,
  input wire [5:0] ol_raw,
  input wire tw_raw,
  input wire tsd_raw,
  input wire ov_raw,
  input wire uv_raw,
  input wire mod_input_a,
  input wire sense_or_mod_b_pin,
  output wire [2:0] half_bridge_hs_on,
  output wire [2:0] half_bridge_ls_on,
  output wire [2:0] half_bridge_hs_fast_off,
  output wire [2:0] half_bridge_ls_fast_off,
  output reg [2:0] high_side_on,
  output reg charge_pump_en,
  output reg [1:0] current_sense_sel,
  output reg current_sense_blank,
  output reg fault_any
);
  reg [23:0] ctrl0_reg;
  reg [5:0] ctrl1_reg;
  reg [16:1] stat_reg;
  reg [16:1] stat_next;
  reg [5:0] oc_q_d_reg;
  reg [CNT_W-1:0] rec_cnt_reg [0:5];
  reg [31:0] c0_wr;
  reg [31:0] c1_wr;
  reg [5:0] want;
  reg [5:0] want_ls;
  reg sel_on;
  integer i;
  integer j;
  integer k;

  wire [5:0] oc_q;
  wire [5:0] ol_q;
  wire tw_q;
  wire tsd_q;
  wire ov_q;
  wire uv_q;
  wire ok_q;
  wire cm_q;

  // Byte-lane merge for partial writes.
  function [31:0] lane_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] sel;
    integer b;
    begin
      lane_merge = old_v;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b]) begin
          lane_merge[8*b +: 8] = new_v[8*b +: 8];
        end
      end
    end
  endfunction

  // Modulation gating of one on bit.
  function gate_mod;
    input on_bit;
    input mod_en;
    input mod_in;
    begin
      gate_mod = on_bit & (~mod_en | mod_in);
    end
  endfunction

  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr = req && wb_we_i;
  wire wr_c0 = wr && (wb_adr_i == `LSD_ADR_CTRL0);
  wire wr_c1 = wr && (wb_adr_i == `LSD_ADR_CTRL1);
  wire wr_st = wr && (wb_adr_i == `LSD_ADR_STAT);
  wire active = ctrl0_reg[`LSD_C0_EN];
  wire run = active && vcc_ok;
  wire [5:0] oc_flag = stat_reg[`LSD_S_OC_LO +: 6];
  wire [5:0] rec_en = ctrl0_reg[`LSD_C0_REC_LO +: 6];
  wire supply_fault = stat_reg[`LSD_S_OV] | stat_reg[`LSD_S_UV];
  wire [5:0] oc_rise = oc_q & ~oc_q_d_reg;
  wire [5:0] drv_on;
  reg [5:0] oc_block;
  reg [5:0] drv_ok;

  always @* begin
    c0_wr = lane_merge({8'h00, ctrl0_reg}, wb_dat_i, wb_sel_i);
    c1_wr = lane_merge({26'h0000000, ctrl1_reg}, wb_dat_i, wb_sel_i);
  end

  // Bus slave: one wait-free answer the cycle after the request.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      if (req) begin
        case (wb_adr_i)
          `LSD_ADR_CTRL0: wb_dat_o <= {8'h00, ctrl0_reg};
          `LSD_ADR_CTRL1: wb_dat_o <= {26'h0000000, ctrl1_reg};
          `LSD_ADR_STAT: wb_dat_o <= {15'h0000, stat_reg, |stat_reg};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // Control registers. The clear-all bit acts once and is not stored.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl0_reg <= `LSD_CTRL0_RST;
      ctrl1_reg <= `LSD_CTRL1_RST;
    end else if (wr_c0 && !c0_wr[`LSD_C0_EN]) begin
      ctrl0_reg <= `LSD_CTRL0_RST;
      ctrl1_reg <= `LSD_CTRL1_RST;
    end else if (wr_c0) begin
      ctrl0_reg <= c0_wr[23:0] & ~(24'h000001 << `LSD_C0_CLR);
    end else if (wr_c1 && active) begin
      ctrl1_reg <= c1_wr[5:0];
    end
  end

  // Fault filters. They are held clear while the logic is not running so
  // that nothing half-counted survives standby.
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : flt
      lsd_filter #(.CYC(`LSD_FILT_CYC), .W(CNT_W)) u_oc (
        .clk(clk), .rst(rst), .clr(!run), .cond(oc_raw[g]), .qual(oc_q[g]));
      lsd_filter #(.CYC(OL_CYC), .W(CNT_W)) u_ol (
        .clk(clk), .rst(rst), .clr(!run), .cond(ol_raw[g] && drv_on[g]), .qual(ol_q[g]));
    end
  endgenerate

  lsd_filter #(.CYC(`LSD_FILT_CYC), .W(CNT_W)) u_tw (
    .clk(clk), .rst(rst), .clr(!run), .cond(tw_raw), .qual(tw_q));
  lsd_filter #(.CYC(`LSD_FILT_CYC), .W(CNT_W)) u_tsd (
    .clk(clk), .rst(rst), .clr(!run), .cond(tsd_raw), .qual(tsd_q));
  lsd_filter #(.CYC(`LSD_FILT_CYC), .W(CNT_W)) u_ov (
    .clk(clk), .rst(rst), .clr(!run), .cond(ov_raw), .qual(ov_q));
  lsd_filter #(.CYC(`LSD_FILT_CYC), .W(CNT_W)) u_uv (
    .clk(clk), .rst(rst), .clr(!run), .cond(uv_raw), .qual(uv_q));
  lsd_filter #(.CYC(`LSD_FILT_CYC), .W(CNT_W)) u_ok (
    .clk(clk), .rst(rst), .clr(!run), .cond(!ov_raw && !uv_raw), .qual(ok_q));

  // Status flags: host and supply-recovery clears are applied first so that a set
  // in the same cycle wins; supply low and standby clear everything last.
  always @* begin
    stat_next = stat_reg;
    if (wr_st) begin
      if (wb_sel_i[0]) begin
        stat_next[7:1] = stat_reg[7:1] & ~wb_dat_i[7:1];
      end
      if (wb_sel_i[1]) begin
        stat_next[12:8] = stat_reg[12:8] & ~wb_dat_i[12:8];
        if (wb_dat_i[`LSD_S_TW] && !tw_raw) begin
          stat_next[`LSD_S_TW] = 1'b0;
        end
        if (wb_dat_i[`LSD_S_TSD] && !tsd_raw) begin
          stat_next[`LSD_S_TSD] = 1'b0;
        end
        stat_next[`LSD_S_OV] = stat_reg[`LSD_S_OV] & ~wb_dat_i[`LSD_S_OV];
      end
      if (wb_sel_i[2]) begin
        stat_next[`LSD_S_UV] = stat_reg[`LSD_S_UV] & ~wb_dat_i[`LSD_S_UV];
      end
    end
    if (!ctrl0_reg[`LSD_C0_SVRD] && ok_q) begin
      stat_next[`LSD_S_OV] = 1'b0;
      stat_next[`LSD_S_UV] = 1'b0;
    end
    if (wr_c0 && c0_wr[`LSD_C0_CLR]) begin
      stat_next = 16'h0000;
    end
    stat_next[`LSD_S_OC_LO +: 6] = stat_next[`LSD_S_OC_LO +: 6] | oc_q;
    stat_next[`LSD_S_OL_LO +: 6] = stat_next[`LSD_S_OL_LO +: 6] | ol_q;
    stat_next[`LSD_S_TW] = stat_next[`LSD_S_TW] | tw_q;
    stat_next[`LSD_S_TSD] = stat_next[`LSD_S_TSD] | tsd_q;
    stat_next[`LSD_S_OV] = stat_next[`LSD_S_OV] | ov_q;
    stat_next[`LSD_S_UV] = stat_next[`LSD_S_UV] | uv_q;
    if (!vcc_ok || (wr_c0 && !c0_wr[`LSD_C0_EN]) || !active) begin
      stat_next = 16'h0000;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      stat_reg <= 16'h0000;
      fault_any <= 1'b0;
      oc_q_d_reg <= 6'h00;
    end else begin
      stat_reg <= stat_next;
      fault_any <= |stat_next;
      oc_q_d_reg <= oc_q;
    end
  end

  // Over-current recovery timers. Each new over-current restarts the
  // timer, which gives the chopped soft start on high inrush loads.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      for (i = 0; i < 6; i = i + 1) begin
        rec_cnt_reg[i] <= {CNT_W{1'b0}};
      end
    end else begin
      for (i = 0; i < 6; i = i + 1) begin
        if (!run) begin
          rec_cnt_reg[i] <= {CNT_W{1'b0}};
        end else if (oc_rise[i]) begin
          rec_cnt_reg[i] <= REC_CYC[CNT_W-1:0];
        end else if (rec_cnt_reg[i] != {CNT_W{1'b0}}) begin
          rec_cnt_reg[i] <= rec_cnt_reg[i] - 1'b1;
        end
      end
    end
  end

  // Open-load and warning flags take no part in drv_ok.
  always @* begin
    for (j = 0; j < 6; j = j + 1) begin
      if (rec_en[j]) begin
        oc_block[j] = (rec_cnt_reg[j] != {CNT_W{1'b0}}) | oc_rise[j];
      end else begin
        oc_block[j] = oc_flag[j] | oc_q[j];
      end
      drv_ok[j] = run & ~supply_fault & ~stat_reg[`LSD_S_TSD] & ~oc_block[j];
    end
  end

  always @* begin
    for (k = 0; k < 3; k = k + 1) begin
      want[k] = gate_mod(ctrl0_reg[2*k], ctrl1_reg[k], mod_input_a) & drv_ok[k];
      want_ls[k] = gate_mod(ctrl0_reg[2*k+1], ctrl1_reg[k], mod_input_a) & drv_ok[k];
      want_ls[k+3] = 1'b0;
    end
    want[3] = gate_mod(ctrl0_reg[6], ctrl1_reg[3], mod_input_a) & drv_ok[3];
    want[4] = gate_mod(ctrl0_reg[7], ctrl1_reg[4], sense_or_mod_b_pin) & drv_ok[4];
    want[5] = gate_mod(ctrl0_reg[8], ctrl1_reg[5], mod_input_a) & drv_ok[5];
  end

  generate
    for (g = 0; g < 3; g = g + 1) begin : hb
      lsd_half_bridge #(.DT(`LSD_XC_CYC), .W(8)) u_hb (
        .clk(clk),
        .rst(rst),
        .want_hs(want[g]),
        .want_ls(want_ls[g]),
        .hs_on(half_bridge_hs_on[g]),
        .ls_on(half_bridge_ls_on[g]),
        .hs_fast_off(half_bridge_hs_fast_off[g]),
        .ls_fast_off(half_bridge_ls_fast_off[g])
      );
    end
  endgenerate

  assign drv_on = {high_side_on, half_bridge_hs_on | half_bridge_ls_on};

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      high_side_on <= 3'h0;
      charge_pump_en <= 1'b0;
    end else begin
      high_side_on <= want[5:3];
      charge_pump_en <= run;
    end
  end

  // Current sense routing and blanking. Changing the selection restarts
  // the blanking so a stale settle time is never trusted.
  always @* begin
    case (ctrl0_reg[`LSD_C0_CMS_LO +: 2])
      2'h0: sel_on = half_bridge_hs_on[0];
      2'h1: sel_on = high_side_on[0];
      2'h2: sel_on = high_side_on[1];
      2'h3: sel_on = high_side_on[2];
      default: sel_on = 1'b0;
    endcase
  end

  lsd_filter #(.CYC(`LSD_FILT_CYC), .W(CNT_W)) u_cm (
    .clk(clk), .rst(rst),
    .clr(!run || (ctrl0_reg[`LSD_C0_CMS_LO +: 2] != current_sense_sel)),
    .cond(sel_on), .qual(cm_q));

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      current_sense_sel <= 2'h0;
      current_sense_blank <= 1'b1;
    end else begin
      current_sense_sel <= ctrl0_reg[`LSD_C0_CMS_LO +: 2];
      current_sense_blank <= !cm_q;
    end
  end
endmodule

// *** lsd_monitor.sv ***
`timescale 1ns/1ps
module lsd_monitor (
  input wire clk,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire vcc_ok,
  input wire [5:0] oc_raw,
  input wire tw_raw,
  input wire tsd_raw,
  input wire ov_raw,
  input wire uv_raw,
  input wire [2:0] half_bridge_hs_on,
  input wire [2:0] half_bridge_ls_on,
  input wire [2:0] high_side_on,
  input wire charge_pump_en,
  input wire [1:0] current_sense_sel,
  input wire current_sense_blank,
  input wire fault_any
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  logic [15:0] raw_n;
  logic [15:0] bad_n;
  logic [15:0] on_n;
  logic [7:0] ls_off_n;
  wire bad = tsd_raw | ov_raw | uv_raw;
  wire raw = (|oc_raw) | tw_raw | bad;
  wire off = (half_bridge_hs_on | half_bridge_ls_on | high_side_on) == 3'h0;
  wire sel_on = (current_sense_sel == 2'h0) ? half_bridge_hs_on[0] : high_side_on[current_sense_sel - 2'h1];

  // Counters saturate so that a long hold never wraps back to a small value.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      raw_n <= 16'h0;
      bad_n <= 16'h0;
      on_n <= 16'h0;
      ls_off_n <= 8'hFF;
    end else begin
      raw_n <= raw ? raw_n + {15'h0, ~&raw_n} : 16'h0;
      bad_n <= bad ? bad_n + {15'h0, ~&bad_n} : 16'h0;
      on_n <= sel_on ? on_n + {15'h0, ~&on_n} : 16'h0;
      ls_off_n <= half_bridge_ls_on[0] ? 8'h0 : ls_off_n + {7'h0, ~&ls_off_n};
    end
  end

  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked next cycle");
  a_reset_quiet: assert property (disable iff (1'b0) rst |-> off && current_sense_blank && !charge_pump_en)
    else $error("output active in reset");
  a_vcc_off: assert property (!vcc_ok [*3] |-> off && !fault_any)
    else $error("output or flag kept with supply low");
  a_standby_off: assert property (!charge_pump_en [*3] |-> off)
    else $error("output on without pump");
  a_bridge_excl: assert property ((half_bridge_hs_on & half_bridge_ls_on) == 3'h0)
    else $error("both bridge switches on");
  a_dead_time: assert property ($rose(half_bridge_hs_on[0]) |-> ls_off_n >= 8'h4E)
    else $error("high switch on too soon");
  a_filter_min: assert property ($rose(fault_any) |-> raw_n >= 16'h04FE)
    else $error("flag set before filter time");
  a_fatal_off: assert property (bad_n >= 16'h050A |-> off)
    else $error("output on during fatal fault");
  a_sense_blank: assert property (sel_on && on_n < 16'h04F6 |-> current_sense_blank)
    else $error("sense not blanked after turn on");

  c_dead: cover property ($rose(half_bridge_ls_on[0]));
  c_unblank: cover property ($fell(current_sense_blank));
  c_fault: cover property ($rose(fault_any));
endmodule

bind lsd_supervisor lsd_monitor mon (.*);

// *** lsd_host.sv ***
`timescale 1ns/1ps
// Register-bus master in the place of the host controller.
module lsd_host (
  input wire clk,
  output logic wb_cyc_i,
  output logic wb_stb_i,
  output logic wb_we_i,
  output logic [3:0] wb_adr_i,
  output logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o
);
  logic [31:0] rdat;
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
  end
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    // Released data is inverted so a stale value cannot look valid.
    wb_dat_i <= ~d;
    if (n >= 20) begin
      tb_top.hang();
    end else begin
      @(posedge clk);
    end
  endtask
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  logic clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, vcc_ok, tw_raw, tsd_raw, ov_raw, uv_raw;
  logic mod_input_a, sense_or_mod_b_pin, charge_pump_en, current_sense_blank, fault_any;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [5:0] oc_raw, ol_raw;
  logic [2:0] half_bridge_hs_on, half_bridge_ls_on, half_bridge_hs_fast_off, half_bridge_ls_fast_off, high_side_on;
  logic [1:0] current_sense_sel;
  int err_total, n_checks, seed, r;
  localparam logic [8:0] hs_all = 9'h1C0;

  lsd_supervisor #(.OL_CYC(200), .REC_CYC(300)) uut (.*);
  lsd_host host (.*);

  function automatic logic [31:0] c0(input logic [8:0] on, input logic [5:0] rec, input logic [1:0] cs, input logic hd);
    return {8'h00, 1'b1, 2'b00, hd, cs, 3'h0, rec, on};
  endfunction
  function automatic logic [2:0] mod_exp(input logic a, input logic b);
    return {a, b, a};
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic hang();
    $display("MISMATCH ack_wait exp 1 seen 0");
    err_total++;
    test_done();
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d);
    cy(3);
  endtask
  task automatic rd(input logic [3:0] a, input string nm, input logic [31:0] exp);
    host.xfer(1'b0, a, 32'h0);
    chk(nm, host.rdat, exp);
  endtask
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    seed = 32'h264F;
    {rst, vcc_ok} = 2'h3;
    {oc_raw, ol_raw, tw_raw, tsd_raw, ov_raw, uv_raw, mod_input_a, sense_or_mod_b_pin} = 18'h0;
    cy(20);
    rst <= 1'b0;
    cy(1);
    rd(4'h0, "ctrl0", 32'h0);
    rd(4'hC, "unmapped", 32'h0);
    chk("pump", charge_pump_en, 1'b0);
    tend("reset");
    wr(4'h0, c0(hs_all, 6'h0, 2'h0, 1'b0));
    chk("hs", high_side_on, 3'h7);
    chk("pump", charge_pump_en, 1'b1);
    rd(4'h0, "ctrl0", c0(hs_all, 6'h0, 2'h0, 1'b0));
    wr(4'h4, 32'h38);
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      mod_input_a <= r[0];
      sense_or_mod_b_pin <= r[1];
      cy(3);
      chk("mod", high_side_on, mod_exp(r[0], r[1]));
    end
    wr(4'h4, 32'h0);
    tend("active");
    wr(4'h0, c0(9'h1C1, 6'h0, 2'h0, 1'b0));
    wr(4'h0, c0(9'h1C2, 6'h0, 2'h0, 1'b0));
    chk("ls_early", half_bridge_ls_on, 3'h0);
    chk("fast_mid", {half_bridge_hs_fast_off, half_bridge_ls_fast_off}, 6'h37);
    cy(90);
    chk("ls", {half_bridge_hs_on, half_bridge_ls_on}, 6'h01);
    chk("fast_end", {half_bridge_hs_fast_off, half_bridge_ls_fast_off}, 6'h3E);
    wr(4'h0, c0(hs_all, 6'h0, 2'h0, 1'b0));
    tend("bridge");
    oc_raw[3] <= 1'b1;
    cy(1250);
    chk("oc_early", high_side_on, 3'h7);
    cy(40);
    chk("oc", high_side_on, 3'h6);
    rd(4'h8, "status", 32'h11);
    oc_raw[3] <= 1'b0;
    cy(400);
    chk("oc_hold", high_side_on, 3'h6);
    wr(4'h8, 32'h10);
    chk("oc_clr", high_side_on, 3'h7);
    wr(4'h0, c0(hs_all, 6'h08, 2'h0, 1'b0));
    oc_raw[3] <= 1'b1;
    cy(1290);
    chk("oc_rec", high_side_on, 3'h6);
    oc_raw[3] <= 1'b0;
    cy(340);
    chk("oc_auto", high_side_on, 3'h7);
    wr(4'h0, c0(hs_all, 6'h0, 2'h0, 1'b0) | 32'h400000);
    rd(4'h8, "clr_all", 32'h0);
    tend("overcurrent");
    tw_raw <= 1'b1;
    cy(1290);
    ol_raw <= 6'h11;
    cy(210);
    chk("info", high_side_on, 3'h7);
    rd(4'h8, "status", 32'h2801);
    wr(4'h8, 32'h2000);
    rd(4'h8, "tw_hot", 32'h2801);
    tw_raw <= 1'b0;
    ol_raw <= 6'h0;
    // The qualified level lags the raw input by a cycle and a set wins.
    cy(2);
    wr(4'h8, 32'h2800);
    rd(4'h8, "tw_cool", 32'h0);
    tsd_raw <= 1'b1;
    cy(1290);
    chk("tsd", high_side_on, 3'h0);
    tsd_raw <= 1'b0;
    cy(50);
    chk("tsd_hold", high_side_on, 3'h0);
    wr(4'h8, 32'h4000);
    chk("tsd_clr", high_side_on, 3'h7);
    tend("thermal");
    uv_raw <= 1'b1;
    cy(1290);
    chk("uv", high_side_on, 3'h0);
    uv_raw <= 1'b0;
    cy(1200);
    chk("uv_wait", high_side_on, 3'h0);
    cy(100);
    chk("uv_back", high_side_on, 3'h7);
    wr(4'h0, c0(hs_all, 6'h0, 2'h0, 1'b1));
    ov_raw <= 1'b1;
    cy(1290);
    chk("ov", high_side_on, 3'h0);
    ov_raw <= 1'b0;
    cy(1400);
    chk("ov_hold", high_side_on, 3'h0);
    wr(4'h8, 32'h8000);
    chk("ov_clr", high_side_on, 3'h7);
    tw_raw <= 1'b1;
    cy(1290);
    tw_raw <= 1'b0;
    vcc_ok <= 1'b0;
    cy(4);
    chk("vcc", {high_side_on, fault_any}, 4'h0);
    vcc_ok <= 1'b1;
    cy(4);
    chk("vcc_back", high_side_on, 3'h7);
    tend("supply");
    for (int c = 0; c < 4; c++) begin
      wr(4'h0, c0(9'h0, 6'h0, c[1:0], 1'b1));
      wr(4'h0, c0((c == 0) ? 9'h001 : (9'h020 << c), 6'h0, c[1:0], 1'b1));
      chk("sel", current_sense_sel, c[1:0]);
      chk("blank", current_sense_blank, 1'b1);
      cy(1300);
      chk("unblank", current_sense_blank, 1'b0);
    end
    tend("sense");
    wr(4'h4, 32'h3F);
    wr(4'h0, 32'h0);
    chk("standby", {half_bridge_hs_on, high_side_on, charge_pump_en}, 7'h0);
    rd(4'h4, "ctrl1", 32'h0);
    wr(4'h4, 32'h3F);
    rd(4'h4, "ctrl1_sb", 32'h0);
    rd(4'h8, "status_sb", 32'h0);
    tend("standby");
    test_done();
  end
endmodule
